// >>> design/ipv_pkg.sv
// Package for the interrupt priority and vectoring unit
package ipv_pkg;
   localparam int NSRC = 6;
   localparam int SRC_W = 3;
   localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
   localparam logic [31:0] ADDR_MODE = 32'h0000_0004;
   localparam logic [31:0] ADDR_ENA = 32'h0000_0008;
   localparam logic [31:0] ADDR_PRI = 32'h0000_000c;
   localparam logic [31:0] ADDR_REQ = 32'h0000_0010;
   localparam logic [31:0] ADDR_REQ_SET = 32'h0000_0014;
   localparam logic [31:0] ADDR_REQ_CLR = 32'h0000_0018;
   localparam logic [31:0] ADDR_EXT_CTRL = 32'h0000_001c;
   localparam logic [31:0] ADDR_PERIPH_EN = 32'h0000_0020;
   localparam logic [31:0] ADDR_AUX_STAT = 32'h0000_0024;
   localparam logic [31:0] ADDR_AUX_CLR = 32'h0000_0028;
   localparam logic [31:0] ADDR_VEC_STAT = 32'h0000_002c;
   localparam logic [31:0] ADDR_DONE = 32'h0000_0030;
   localparam int CTRL_GIE_BIT = 7;
   localparam int EXT_AUX_EN_BIT = 5;
   localparam logic [7:0] CONV_MASK = 8'h20;
   localparam logic [7:0] SUM_MASK = 8'h40;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] EXT_RST = 8'h00;
   localparam logic [7:0] PERIPH_RST = 8'h00;
   localparam logic [15:0] AUX_VECTOR = 16'h0033;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic aux;
      logic [SRC_W-1:0] src;
   } ipv_vec_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } ipv_svc_e;
endpackage

// >>> design/ipv_irq_unit.sv
// Interrupt priority and vectoring unit with AXI4-Lite register slave
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module ipv_irq_unit #(
   parameter int NSRC = ipv_pkg::NSRC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Interrupt sources
   input wire logic [NSRC-1:0] src_in,
   input wire logic conv_done,
   input wire logic sum_done,
   // Core side
   output ipv_pkg::ipv_vec_s vec_out,
   input wire logic vec_ack,
   input wire logic isr_done,
   output logic irq_out,
   // AXI4-Lite slave
   input wire logic [31:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [31:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   logic rst_s1, rst_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1 <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_q <= rst_s1;
      end
   end

   logic [7:0] ctrl, ext_ctrl, periph_en, aux_stat;
   logic [NSRC-1:0] mode, ena, pri, req, src_q;
   logic [NSRC-1:0] in_svc_lo, in_svc_hi;
   logic in_svc_aux;
   logic conv_q, sum_q;
   ipv_pkg::ipv_svc_e svc_state;
   localparam int SRC_W = ipv_pkg::SRC_W;

   // AXI write channel: address and data taken in either order
   logic aw_held, w_held;
   logic [31:0] aw_addr, w_data;
   logic [3:0] w_strb;
   logic wr_go;
   assign s_awready = !aw_held && !s_bvalid;
   assign s_wready = !w_held && !s_bvalid;
   assign wr_go = aw_held && w_held && !s_bvalid;
   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 32'h0000_0000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= ipv_pkg::RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= wr_hit(aw_addr) ? ipv_pkg::RESP_OKAY : ipv_pkg::RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic wr_hit(input logic [31:0] a);
      case (a)
         ipv_pkg::ADDR_CTRL, ipv_pkg::ADDR_MODE, ipv_pkg::ADDR_ENA, ipv_pkg::ADDR_PRI,
         ipv_pkg::ADDR_REQ_SET, ipv_pkg::ADDR_REQ_CLR, ipv_pkg::ADDR_EXT_CTRL,
         ipv_pkg::ADDR_PERIPH_EN, ipv_pkg::ADDR_AUX_CLR, ipv_pkg::ADDR_DONE: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   endfunction

   // Only byte lane 0 carries register bits
   logic wr_en;
   assign wr_en = wr_go && w_strb[0];
   logic [7:0] wbyte;
   assign wbyte = w_data[7:0];

   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         ctrl <= ipv_pkg::CTRL_RST;
         ext_ctrl <= ipv_pkg::EXT_RST;
         periph_en <= ipv_pkg::PERIPH_RST;
         mode <= '0;
         ena <= '0;
         pri <= '0;
      end else if (wr_en) begin
         case (aw_addr)
            ipv_pkg::ADDR_CTRL: ctrl <= wbyte;
            ipv_pkg::ADDR_EXT_CTRL: ext_ctrl <= wbyte;
            ipv_pkg::ADDR_PERIPH_EN: periph_en <= wbyte;
            ipv_pkg::ADDR_MODE: mode <= wbyte[NSRC-1:0];
            ipv_pkg::ADDR_ENA: ena <= wbyte[NSRC-1:0];
            ipv_pkg::ADDR_PRI: pri <= wbyte[NSRC-1:0];
            default: ;
         endcase
      end
   end

   logic gie, aux_en;
   assign gie = ctrl[ipv_pkg::CTRL_GIE_BIT];
   assign aux_en = ext_ctrl[ipv_pkg::EXT_AUX_EN_BIT];

   // Request flags, one per source
   logic [NSRC-1:0] sw_set, sw_clr, take_src;
   assign sw_set = (wr_en && aw_addr == ipv_pkg::ADDR_REQ_SET) ? wbyte[NSRC-1:0] : '0;
   assign sw_clr = (wr_en && aw_addr == ipv_pkg::ADDR_REQ_CLR) ? wbyte[NSRC-1:0] : '0;
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         logic hw_hit;
         // Edge mode latches a rising edge; level mode follows the pin
         assign hw_hit = mode[gi] ? (src_in[gi] && !src_q[gi]) : src_in[gi];
         always_ff @(posedge ref_clk or negedge rst_q) begin
            if (!rst_q) begin
               req[gi] <= 1'b0;
               src_q[gi] <= 1'b0;
            end else begin
               src_q[gi] <= src_in[gi];
               // Hardware or software set beats any clear in the same cycle
               if (hw_hit || sw_set[gi]) begin
                  req[gi] <= 1'b1;
               end else if (sw_clr[gi] || take_src[gi]) begin
                  req[gi] <= 1'b0;
               end else if (!mode[gi]) begin
                  req[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Aux status flags, set by enabled peripheral events
   logic conv_rise, sum_rise;
   logic [7:0] aux_set, aux_clr;
   assign conv_rise = conv_done && !conv_q;
   assign sum_rise = sum_done && !sum_q;
   assign aux_set = (conv_rise ? (periph_en & ipv_pkg::CONV_MASK) : 8'h00)
                  | (sum_rise ? (periph_en & ipv_pkg::SUM_MASK) : 8'h00);
   assign aux_clr = (wr_en && aw_addr == ipv_pkg::ADDR_AUX_CLR) ? wbyte : 8'h00;
   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         conv_q <= 1'b0;
         sum_q <= 1'b0;
         aux_stat <= 8'h00;
      end else begin
         conv_q <= conv_done;
         sum_q <= sum_done;
         aux_stat <= aux_set | (aux_stat & ~aux_clr);
      end
   end

   // Arbitration: aux first, then high-priority, then low, each by index
   logic aux_req;
   logic [NSRC-1:0] elig;
   assign aux_req = aux_en && (|(aux_stat & (ipv_pkg::CONV_MASK | ipv_pkg::SUM_MASK)));
   assign elig = req & ena & {NSRC{gie}};

   ipv_pkg::ipv_vec_s next_vec;
   always_comb begin
      next_vec = '0;
      if (aux_req && !in_svc_aux) begin
         next_vec.valid = 1'b1;
         next_vec.aux = 1'b1;
         next_vec.addr = ipv_pkg::AUX_VECTOR;
      end else if (!in_svc_aux) begin
         for (int i = NSRC - 1; i >= 0; i--) begin
            if (elig[i] && !pri[i] && in_svc_lo == '0 && in_svc_hi == '0
                && !(|(elig & pri))) begin
               next_vec.valid = 1'b1;
               next_vec.src = SRC_W'(i);
            end
         end
         for (int i = NSRC - 1; i >= 0; i--) begin
            if (elig[i] && pri[i] && in_svc_hi == '0) begin
               next_vec.valid = 1'b1;
               next_vec.src = SRC_W'(i);
            end
         end
         next_vec.addr = ipv_pkg::VEC_BASE
                       + 16'(ipv_pkg::VEC_STEP * 16'(next_vec.src));
      end
   end

   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         vec_out <= '0;
      end else begin
         vec_out <= next_vec;
      end
   end
   assign irq_out = vec_out.valid;

   // Service tracking: acknowledged vector enters service until done
   logic vec_take;
   assign vec_take = vec_ack && vec_out.valid && next_vec.valid;
   always_comb begin
      take_src = '0;
      if (vec_take && !vec_out.aux && !mode[vec_out.src] == 1'b0) begin
         take_src[vec_out.src] = 1'b1;
      end
   end
   logic done_wr;
   assign done_wr = isr_done || (wr_en && aw_addr == ipv_pkg::ADDR_DONE);
   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         in_svc_aux <= 1'b0;
         in_svc_hi <= '0;
         in_svc_lo <= '0;
         svc_state <= ipv_pkg::ST_IDLE;
      end else begin
         case (svc_state)
            ipv_pkg::ST_IDLE: begin
               if (vec_take) begin
                  svc_state <= ipv_pkg::ST_BUSY;
               end
            end
            ipv_pkg::ST_BUSY: begin
               if (done_wr && !vec_take) begin
                  svc_state <= ipv_pkg::ST_IDLE;
               end
            end
            default: svc_state <= ipv_pkg::ST_IDLE;
         endcase
         // Newest level done first: aux, then high, then low
         if (done_wr) begin
            if (in_svc_aux) begin
               in_svc_aux <= 1'b0;
            end else if (in_svc_hi != '0) begin
               in_svc_hi <= '0;
            end else begin
               in_svc_lo <= '0;
            end
         end
         if (vec_take) begin
            if (vec_out.aux) begin
               in_svc_aux <= 1'b1;
            end else if (pri[vec_out.src]) begin
               in_svc_hi[vec_out.src] <= 1'b1;
            end else begin
               in_svc_lo[vec_out.src] <= 1'b1;
            end
         end
      end
   end

   // AXI read channel
   logic [7:0] rd_byte;
   logic rd_ok;
   assign s_arready = !s_rvalid;
   always_comb begin
      rd_ok = 1'b1;
      rd_byte = 8'h00;
      case (s_araddr)
         ipv_pkg::ADDR_CTRL: rd_byte = ctrl;
         ipv_pkg::ADDR_EXT_CTRL: rd_byte = ext_ctrl;
         ipv_pkg::ADDR_PERIPH_EN: rd_byte = periph_en;
         ipv_pkg::ADDR_MODE: rd_byte = 8'(mode);
         ipv_pkg::ADDR_ENA: rd_byte = 8'(ena);
         ipv_pkg::ADDR_PRI: rd_byte = 8'(pri);
         ipv_pkg::ADDR_REQ: rd_byte = 8'(req);
         ipv_pkg::ADDR_AUX_STAT: rd_byte = aux_stat;
         ipv_pkg::ADDR_VEC_STAT: rd_byte = {vec_out.valid, vec_out.aux, in_svc_aux,
                                            svc_state == ipv_pkg::ST_BUSY, 1'b0, vec_out.src};
         ipv_pkg::ADDR_REQ_SET, ipv_pkg::ADDR_REQ_CLR, ipv_pkg::ADDR_AUX_CLR,
         ipv_pkg::ADDR_DONE: rd_byte = 8'h00;
         default: rd_ok = 1'b0;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= ipv_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rdata <= {24'h00_0000, rd_byte};
         s_rresp <= rd_ok ? ipv_pkg::RESP_OKAY : ipv_pkg::RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   // Checks
   AST_GIE_BLOCKS: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (!gie && !aux_req) |=> !vec_out.valid)
      else $error("vector raised with global enable clear");
   AST_AUX_NO_GIE: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (aux_req && !in_svc_aux) |=> (vec_out.valid && vec_out.aux))
      else $error("aux request not vectored");
   AST_AUX_EN: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (!aux_en) |-> !(next_vec.aux))
      else $error("aux vectored while disabled");
   AST_AUX_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_q)
      vec_out.aux |-> vec_out.addr == ipv_pkg::AUX_VECTOR)
      else $error("aux vector address wrong");
   AST_SUM_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (periph_en == 8'h40 && conv_rise && !aux_stat[5] && !aux_clr[5]) |=> !aux_stat[5])
      else $error("conversion flagged while masked");
   AST_BOTH: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (periph_en == 8'h60 && conv_rise) |=> aux_stat[5])
      else $error("conversion event not flagged");
   AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (sum_rise && periph_en[6]) |=> aux_stat[6])
      else $error("summation flag lost");
   AST_SW_REQ: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (sw_set[0]) |=> req[0])
      else $error("software request not taken");
   AST_HI_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (next_vec.valid && !next_vec.aux) |-> (pri[next_vec.src] || !(|(elig & pri))))
      else $error("low priority beat high");
   AST_INDEX: assert property (@(posedge ref_clk) disable iff (!rst_q)
      (next_vec.valid && !next_vec.aux && elig[0] && pri[0] == pri[next_vec.src]
       && in_svc_hi == '0 && in_svc_lo == '0) |-> next_vec.src == '0)
      else $error("index order broken");
   COV_AUX: cover property (@(posedge ref_clk) vec_take && vec_out.aux);
   COV_HI: cover property (@(posedge ref_clk) vec_take && pri[vec_out.src]);
   COV_LO: cover property (@(posedge ref_clk) vec_take && !vec_out.aux && !pri[vec_out.src]);
endmodule

// >>> testbench/ipv_core_model.sv
// Core model that takes offered vectors and runs a 16-cycle service routine
`timescale 1ns/100ps
module ipv_core_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Vector interface
   input wire ipv_pkg::ipv_vec_s vec,
   output logic vec_ack,
   output logic isr_done,
   // Bench control and view
   input wire logic [3:0] ack_wait,
   output logic [15:0] last_addr,
   output logic [7:0] n_taken,
   output logic in_isr
);
   logic [3:0] cnt;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         vec_ack <= 1'b0;
         isr_done <= 1'b0;
         in_isr <= 1'b0;
         last_addr <= 16'h0000;
         n_taken <= 8'h00;
      end else begin
         vec_ack <= 1'b0;
         isr_done <= 1'b0;
         if (in_isr) begin
            cnt <= cnt + 4'h1;
            // Long routine so software can clear aux flags before it ends
            if (cnt == 4'hf) begin
               in_isr <= 1'b0;
               isr_done <= 1'b1;
               cnt <= 4'h0;
            end
         end else if (vec.valid && !vec_ack) begin
            cnt <= cnt + 4'h1;
            // Nonzero wait gives a slow core
            if (cnt >= ack_wait) begin
               vec_ack <= 1'b1;
               last_addr <= vec.addr;
               n_taken <= n_taken + 8'h01;
               in_isr <= 1'b1;
               cnt <= 4'h0;
            end
         end else begin
            cnt <= 4'h0;
         end
      end
   end
endmodule

// >>> testbench/tb_top.sv
// Self-checking testbench for the interrupt vectoring unit
`timescale 1ns/100ps
module tb_top;
   logic ref_clk, rst_n, conv_done, sum_done, vec_ack, isr_done, irq_out, in_isr;
   logic [5:0] src_in;
   ipv_pkg::ipv_vec_s vec_out;
   logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, rdv;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready;
   logic [3:0] s_wstrb, ack_wait;
   logic [1:0] s_bresp, s_rresp, rsp;
   logic [15:0] last_addr;
   logic [7:0] n_taken;
   int n_errors = 0;
   int num_checks = 0;

   ipv_irq_unit dut (.ref_clk, .rst_n, .src_in, .conv_done, .sum_done, .vec_out, .vec_ack,
      .isr_done, .irq_out, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
      .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
      .s_rresp, .s_rvalid, .s_rready);
   ipv_core_model core (.ref_clk, .rst_n, .vec(vec_out), .vec_ack, .isr_done, .ack_wait,
      .last_addr, .n_taken, .in_isr);

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      end_sim;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   // Ready and response are read at the falling edge, stable until the next rise
   task automatic axi(input logic w, input logic [31:0] a, input logic [7:0] d);
      logic ha, hw, hd;
      int t;
      t = 0;
      hd = 1'b0;
      @(posedge ref_clk);
      if (w) begin
         s_awaddr <= a;
         s_awvalid <= 1'b1;
         s_wdata <= {24'h000000, d};
         s_wvalid <= 1'b1;
         s_bready <= 1'b1;
      end else begin
         s_araddr <= a;
         s_arvalid <= 1'b1;
         s_rready <= 1'b1;
      end
      while (!hd && t < 50) begin
         @(negedge ref_clk);
         ha = w ? (s_awvalid && s_awready) : (s_arvalid && s_arready);
         hw = s_wvalid && s_wready;
         hd = w ? s_bvalid : s_rvalid;
         rsp = w ? s_bresp : s_rresp;
         rdv = s_rdata;
         @(posedge ref_clk);
         if (ha && w)
            s_awvalid <= 1'b0;
         if (ha && !w)
            s_arvalid <= 1'b0;
         if (hw)
            s_wvalid <= 1'b0;
         if (hd) begin
            s_bready <= 1'b0;
            s_rready <= 1'b0;
         end
         t++;
      end
      if (!hd)
         chk(32'h1, 32'h0);
   endtask

   task automatic expv(input logic [15:0] e);
      logic [7:0] n0;
      int t;
      n0 = n_taken;
      t = 0;
      while (n_taken === n0 && t < 60) begin
         @(negedge ref_clk);
         t++;
      end
      chk({8'h00, n_taken, last_addr}, {8'h00, n0 + 8'h01, e});
   endtask

   task automatic nov(input int n);
      logic [7:0] n0;
      n0 = n_taken;
      repeat (n) @(negedge ref_clk);
      chk({23'h000000, irq_out, n_taken}, {23'h000000, 1'b0, n0});
   endtask

   task automatic pul(input logic s);
      @(posedge ref_clk);
      sum_done <= s;
      conv_done <= !s;
      @(posedge ref_clk);
      sum_done <= 1'b0;
      conv_done <= 1'b0;
   endtask

   initial begin
      rst_n = 1'b0;
      src_in = 6'h00;
      {conv_done, sum_done, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 7'h00;
      s_awaddr = 32'h0;
      s_wdata = 32'h0;
      s_araddr = 32'h0;
      s_wstrb = 4'h1;
      ack_wait = 4'h0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      axi(1'b0, ipv_pkg::ADDR_CTRL, 8'h00);
      chk(rdv, 32'h0);
      axi(1'b0, ipv_pkg::ADDR_EXT_CTRL, 8'h00);
      chk(rdv, 32'h0);
      axi(1'b0, 32'h0000_0040, 8'h00);
      chk({30'h0, rsp}, {30'h0, ipv_pkg::RESP_SLVERR});
      axi(1'b1, ipv_pkg::ADDR_MODE, 8'h3f);
      axi(1'b1, ipv_pkg::ADDR_ENA, 8'h01);
      axi(1'b1, ipv_pkg::ADDR_REQ_SET, 8'h01);
      nov(12);
      axi(1'b0, ipv_pkg::ADDR_REQ, 8'h00);
      chk(rdv, 32'h1);
      axi(1'b0, ipv_pkg::ADDR_VEC_STAT, 8'h00);
      chk(rdv, 32'h0);
      axi(1'b1, ipv_pkg::ADDR_CTRL, 8'h80);
      expv(16'h0003);
      axi(1'b1, ipv_pkg::ADDR_ENA, 8'h3f);
      axi(1'b1, ipv_pkg::ADDR_REQ_SET, 8'h14);
      expv(16'h0013);
      expv(16'h0023);
      axi(1'b1, ipv_pkg::ADDR_PRI, 8'h10);
      axi(1'b1, ipv_pkg::ADDR_REQ_SET, 8'h14);
      expv(16'h0023);
      expv(16'h0013);
      axi(1'b1, ipv_pkg::ADDR_PRI, 8'h00);
      axi(1'b1, ipv_pkg::ADDR_MODE, 8'h00);
      @(posedge ref_clk);
      src_in <= 6'h02;
      expv(16'h000b);
      expv(16'h000b);
      @(posedge ref_clk);
      src_in <= 6'h00;
      nov(20);
      axi(1'b1, ipv_pkg::ADDR_MODE, 8'h02);
      @(posedge ref_clk);
      src_in <= 6'h02;
      expv(16'h000b);
      nov(20);
      @(posedge ref_clk);
      src_in <= 6'h00;
      axi(1'b1, ipv_pkg::ADDR_CTRL, 8'h00);
      axi(1'b1, ipv_pkg::ADDR_EXT_CTRL, 8'h20);
      axi(1'b1, ipv_pkg::ADDR_PERIPH_EN, 8'h40);
      pul(1'b0);
      nov(15);
      pul(1'b1);
      expv(16'h0033);
      axi(1'b0, ipv_pkg::ADDR_AUX_STAT, 8'h00);
      chk(rdv & 32'h40, 32'h40);
      axi(1'b1, ipv_pkg::ADDR_AUX_CLR, 8'h60);
      axi(1'b0, ipv_pkg::ADDR_AUX_STAT, 8'h00);
      chk(rdv & 32'h60, 32'h0);
      axi(1'b1, ipv_pkg::ADDR_PERIPH_EN, 8'h60);
      pul(1'b0);
      expv(16'h0033);
      axi(1'b0, ipv_pkg::ADDR_AUX_STAT, 8'h00);
      chk(rdv & 32'h20, 32'h20);
      axi(1'b1, ipv_pkg::ADDR_AUX_CLR, 8'h60);
      pul(1'b1);
      expv(16'h0033);
      axi(1'b1, ipv_pkg::ADDR_AUX_CLR, 8'h60);
      axi(1'b1, ipv_pkg::ADDR_EXT_CTRL, 8'h00);
      pul(1'b1);
      nov(20);
      axi(1'b1, ipv_pkg::ADDR_AUX_CLR, 8'h60);
      axi(1'b1, ipv_pkg::ADDR_CTRL, 8'h80);
      axi(1'b1, ipv_pkg::ADDR_EXT_CTRL, 8'h20);
      axi(1'b1, ipv_pkg::ADDR_PRI, 8'h01);
      axi(1'b1, ipv_pkg::ADDR_MODE, 8'h01);
      // Slow core so both requests stand together at arbitration
      ack_wait <= 4'h6;
      @(posedge ref_clk);
      src_in <= 6'h01;
      sum_done <= 1'b1;
      expv(16'h0033);
      // Flag must go inside the routine, or aux wins again
      axi(1'b1, ipv_pkg::ADDR_AUX_CLR, 8'h60);
      expv(16'h0003);
      end_sim;
   end
endmodule
